/* include/dscp_map_pkg.sv */
/*
 * Shared constants and state encodings for the DiffServ priority table.
 * Assumes a 32-bit AXI4-Lite register bus and one switch clock.
 */
package dscp_map_pkg;

	// =====================================================================
	// Widths
	localparam int DATA_W   = 32;
	localparam int ADDR_W   = 10;
	localparam int IDX_W    = 8;
	localparam int REG_W    = 8;
	localparam int NUM_REGS = 16;
	localparam int FIELD_W  = 2;
	localparam int CODE_W   = 6;
	localparam int NUM_CODE = 64;
	localparam int TBL_W    = NUM_REGS * REG_W;
	localparam int CNT_W    = 16;
	localparam int IDX_LSB  = 2;

	// =====================================================================
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TBL_FIRST    = 8'h60;
	localparam logic [IDX_W-1:0] IDX_CODES_0C_0F  = 8'h63;
	localparam logic [IDX_W-1:0] IDX_CODES_10_13  = 8'h64;
	localparam logic [IDX_W-1:0] IDX_CODES_14_17  = 8'h65;
	localparam logic [IDX_W-1:0] IDX_CODES_18_1B  = 8'h66;
	localparam logic [IDX_W-1:0] IDX_CODES_1C_1F  = 8'h67;
	localparam logic [IDX_W-1:0] IDX_CODES_20_23  = 8'h68;
	localparam logic [IDX_W-1:0] IDX_CODES_24_27  = 8'h69;
	localparam logic [IDX_W-1:0] IDX_CODES_28_2B  = 8'h6A;
	localparam logic [IDX_W-1:0] IDX_TBL_LAST     = 8'h6F;
	localparam logic [IDX_W-1:0] IDX_CTRL         = 8'h80;
	localparam logic [IDX_W-1:0] IDX_STAT         = 8'h81;
	localparam logic [IDX_W-1:0] IDX_HITS         = 8'h82;

	// =====================================================================
	// Fields and reset values
	localparam logic [REG_W-1:0] TBL_RST       = 8'h00;
	localparam logic             CTRL_EN_RST   = 1'h0;
	localparam int               CTRL_EN_BIT   = 0;
	localparam int               STAT_PRIO_LSB = 0;
	localparam int               STAT_CODE_LSB = 2;
	localparam int               STAT_HIT_BIT  = 8;
	localparam int               STAT_VLD_BIT  = 9;
	localparam logic [1:0]       RESP_OKAY     = 2'h0;
	localparam logic [1:0]       RESP_SLVERR   = 2'h2;

	// =====================================================================
	// Bus state machines, one-hot
	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} rd_state_t;

endpackage

/* include/prio_lookup_if.sv */
/*
 * Carrier between the register bank and the table lookup.
 * Assumes both ends sit on the same switch clock.
 */
`timescale 1ns/100ps
interface prio_lookup_if;
	import dscp_map_pkg::*;

	logic [TBL_W-1:0]   table_bits;
	logic [REG_W-1:0]   tos;
	logic               frame_ip;
	logic               ds_en;
	logic [FIELD_W-1:0] alt_prio;
	logic [FIELD_W-1:0] prio;
	logic               use_tbl;

	// Register bank side
	modport bank (
		output table_bits,
		output tos,
		output frame_ip,
		output ds_en,
		output alt_prio,
		input  prio,
		input  use_tbl
	);

	// Lookup side
	modport lkp (
		input  table_bits,
		input  tos,
		input  frame_ip,
		input  ds_en,
		input  alt_prio,
		output prio,
		output use_tbl
	);
endinterface

/* logic/dscp_prio_lookup.sv */
/*
 * Combinational DiffServ code to priority lookup.
 * Assumes the table and the frame fields arrive on the carrier; the
 * caller registers the result.
 */
`timescale 1ns/100ps
module dscp_prio_lookup
	import dscp_map_pkg::*;
(
	prio_lookup_if.lkp lk
);

	logic [CODE_W-1:0]  code;
	logic [FIELD_W-1:0] entry [NUM_CODE];

	// =====================================================================
	// Table unpacking
	// One field per code, lowest code in the lowest bits
	genvar i;
	generate
		for (i = 0; i < NUM_CODE; i++) begin : g_entry
			assign entry[i] = lk.table_bits[i*FIELD_W +: FIELD_W];
		end
	endgenerate

	// =====================================================================
	// Selection
	// Upper six bits of the TOS or traffic class byte
	assign code = lk.tos[REG_W-1:IDX_LSB];

	// Non-IP frames and disabled mode fall back to the other classifiers
	assign lk.use_tbl = lk.frame_ip & lk.ds_en;
	assign lk.prio    = lk.use_tbl ? entry[code] : lk.alt_prio;

endmodule

/* logic/dscp_prio_map.sv */
/*
 * DiffServ priority table: sixteen 8-bit registers of four 2-bit
 * priority fields, an enable, a status word and a hit counter, reached
 * over AXI4-Lite, plus the registered priority answer to the classifier.
 * Assumes the classifier and the bus master run on CLK and that the
 * classifier presents one frame per TOS_VALID cycle.
 */
// Functional notes
// - Code is TOS byte bits seven to two
// - Selected field is priority; fields RW, reset zero
// - Four codes per register, ascending from bit zero
// - Codes 0C to 0E in low three fields
// - Index 64 holds codes 10 to 13
// - Index 65 holds codes 14 to 17
// - Index 66 holds codes 18 to 1B
// - Index 67 holds codes 1C to 1F
// - Index 68 holds codes 20 to 23
// - Index 69 holds codes 24 to 27
// - Index 6A holds codes 28 to 2B
// - 128 bits, 64 fully decoded entries
// - Codes 00 to 03 at index 60
// - Code 3F in top field of 6F
`timescale 1ns/100ps
module dscp_prio_map
	import dscp_map_pkg::*;
(
	input  wire logic                CLK,
	input  wire logic                RST,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]   AWADDR,
	input  wire logic                AWVALID,
	output logic                     AWREADY,
	input  wire logic [DATA_W-1:0]   WDATA,
	input  wire logic [DATA_W/8-1:0] WSTRB,
	input  wire logic                WVALID,
	output logic                     WREADY,
	output logic [1:0]               BRESP,
	output logic                     BVALID,
	input  wire logic                BREADY,
	input  wire logic [ADDR_W-1:0]   ARADDR,
	input  wire logic                ARVALID,
	output logic                     ARREADY,
	output logic [DATA_W-1:0]        RDATA,
	output logic [1:0]               RRESP,
	output logic                     RVALID,
	input  wire logic                RREADY,
	// Classifier side
	input  wire logic                TOS_VALID,
	input  wire logic [REG_W-1:0]    TOS_BYTE,
	input  wire logic                FRAME_IS_IP,
	input  wire logic [FIELD_W-1:0]  ALT_PRIO,
	output logic                     PRIO_VALID,
	output logic [FIELD_W-1:0]       PRIO,
	output logic                     PRIO_FROM_TABLE
);

	// =====================================================================
	// State
	typedef struct packed {
		wr_state_t                       wr;
		rd_state_t                       rd;
		logic                            aw_got;
		logic                            w_got;
		logic [IDX_W-1:0]                aw_idx;
		logic [REG_W-1:0]                w_byte;
		logic                            w_lane;
		logic [1:0]                      bresp;
		logic [DATA_W-1:0]               rdata;
		logic [1:0]                      rresp;
		logic [NUM_REGS-1:0][REG_W-1:0]  tbl;
		logic                            ds_en;
		logic                            prio_valid;
		logic [FIELD_W-1:0]              prio;
		logic                            prio_tbl;
		logic                            last_vld;
		logic                            last_hit;
		logic [CODE_W-1:0]               last_code;
		logic [FIELD_W-1:0]              last_prio;
		logic [CNT_W-1:0]                hit_cnt;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic [IDX_W-1:0]  ar_idx;
	logic [DATA_W-1:0] rd_word;
	logic              rd_ok;
	logic              wr_hit_clr;
	logic              hit_evt;

	prio_lookup_if lk ();

	// =====================================================================
	// Decoding helpers
	// Table window test, shared by the read and write paths
	function automatic logic is_tbl(input logic [IDX_W-1:0] idx);
		return (idx >= IDX_TBL_FIRST) && (idx <= IDX_TBL_LAST);
	endfunction

	// Table row from a bus index; row n carries codes 4n to 4n+3
	function automatic logic [3:0] tbl_row(input logic [IDX_W-1:0] idx);
		logic [IDX_W-1:0] d;
		d = idx - IDX_TBL_FIRST;
		return d[3:0];
	endfunction

	// Any index that answers OKAY
	function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
		return is_tbl(idx) || (idx == IDX_CTRL) || (idx == IDX_STAT) ||
			(idx == IDX_HITS);
	endfunction

	// =====================================================================
	// Lookup hookup
	// Packed rows flatten so that code 0 lands in bits 1-0
	assign lk.table_bits = st_r.tbl;
	assign lk.tos        = TOS_BYTE;
	assign lk.frame_ip   = FRAME_IS_IP;
	assign lk.ds_en      = st_r.ds_en;
	assign lk.alt_prio   = ALT_PRIO;

	dscp_prio_lookup u_lookup (
		.lk (lk.lkp)
	);

	// =====================================================================
	// Bus handshakes
	// Address and data are taken independently, one of each per write
	assign AWREADY = (st_r.wr == WR_IDLE) && !st_r.aw_got;
	assign WREADY  = (st_r.wr == WR_IDLE) && !st_r.w_got;
	assign BVALID  = (st_r.wr == WR_RESP);
	assign BRESP   = st_r.bresp;
	assign ARREADY = (st_r.rd == RD_IDLE);
	assign RVALID  = (st_r.rd == RD_DATA);
	assign RDATA   = st_r.rdata;
	assign RRESP   = st_r.rresp;

	// Classifier answer, one cycle after TOS_VALID
	assign PRIO_VALID      = st_r.prio_valid;
	assign PRIO            = st_r.prio;
	assign PRIO_FROM_TABLE = st_r.prio_tbl;

	assign ar_idx = ARADDR[ADDR_W-1:IDX_LSB];

	// =====================================================================
	// Read word assembly
	// Unused bits read zero; unmapped indices read zero with SLVERR
	always_comb begin
		rd_word = '0;
		rd_ok   = is_mapped(ar_idx);
		if (is_tbl(ar_idx)) begin
			rd_word[REG_W-1:0] = st_r.tbl[tbl_row(ar_idx)];
		end else if (ar_idx == IDX_CTRL) begin
			rd_word[CTRL_EN_BIT] = st_r.ds_en;
		end else if (ar_idx == IDX_STAT) begin
			rd_word[STAT_PRIO_LSB +: FIELD_W] = st_r.last_prio;
			rd_word[STAT_CODE_LSB +: CODE_W]  = st_r.last_code;
			rd_word[STAT_HIT_BIT]             = st_r.last_hit;
			rd_word[STAT_VLD_BIT]             = st_r.last_vld;
		end else if (ar_idx == IDX_HITS) begin
			rd_word[CNT_W-1:0] = st_r.hit_cnt;
		end
	end

	// =====================================================================
	// Next state
	always_comb begin
		st_nxt     = st_r;
		wr_hit_clr = 1'b0;
		hit_evt    = TOS_VALID && lk.use_tbl;

		// Write path: capture address and data in either order
		case (st_r.wr)
			WR_IDLE: begin
				if (AWVALID && AWREADY) begin
					st_nxt.aw_got = 1'b1;
					st_nxt.aw_idx = AWADDR[ADDR_W-1:IDX_LSB];
				end
				if (WVALID && WREADY) begin
					st_nxt.w_got  = 1'b1;
					st_nxt.w_byte = WDATA[REG_W-1:0];
					st_nxt.w_lane = WSTRB[0];
				end
				// Commit one cycle after both halves are held
				if (st_r.aw_got && st_r.w_got) begin
					st_nxt.aw_got = 1'b0;
					st_nxt.w_got  = 1'b0;
					st_nxt.wr     = WR_RESP;
					st_nxt.bresp  = is_mapped(st_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
					// Only byte lane 0 carries register bits
					if (st_r.w_lane) begin
						if (is_tbl(st_r.aw_idx)) begin
							st_nxt.tbl[tbl_row(st_r.aw_idx)] = st_r.w_byte;
						end else if (st_r.aw_idx == IDX_CTRL) begin
							st_nxt.ds_en = st_r.w_byte[CTRL_EN_BIT];
						end
					end
					// Any write to the hit counter clears it
					if (st_r.aw_idx == IDX_HITS) begin
						wr_hit_clr = 1'b1;
					end
				end
			end
			WR_RESP: begin
				if (BREADY) begin
					st_nxt.wr = WR_IDLE;
				end
			end
			default: begin
				st_nxt.wr     = WR_IDLE;
				st_nxt.aw_got = 1'b0;
				st_nxt.w_got  = 1'b0;
			end
		endcase

		// Read path: data is sampled when the address is taken
		case (st_r.rd)
			RD_IDLE: begin
				if (ARVALID) begin
					st_nxt.rd    = RD_DATA;
					st_nxt.rdata = rd_word;
					st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
				end
			end
			RD_DATA: begin
				if (RREADY) begin
					st_nxt.rd = RD_IDLE;
				end
			end
			default: begin
				st_nxt.rd = RD_IDLE;
			end
		endcase

		// Classifier answer; value holds between frames
		st_nxt.prio_valid = TOS_VALID;
		if (TOS_VALID) begin
			st_nxt.prio     = lk.prio;
			st_nxt.prio_tbl = lk.use_tbl;
			// Status snapshot of the latest frame
			st_nxt.last_vld  = 1'b1;
			st_nxt.last_hit  = lk.use_tbl;
			st_nxt.last_code = TOS_BYTE[REG_W-1:IDX_LSB];
			st_nxt.last_prio = lk.prio;
		end

		// A hit in the clearing cycle still counts, so it is not lost
		if (wr_hit_clr) begin
			st_nxt.hit_cnt = hit_evt ? {{(CNT_W-1){1'b0}}, 1'b1} : '0;
		end else if (hit_evt) begin
			st_nxt.hit_cnt = st_r.hit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// =====================================================================
	// State register
	// Synchronous reset: table fields and the enable return to defaults
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_r       <= '0;
			st_r.wr    <= WR_IDLE;
			st_r.rd    <= RD_IDLE;
			st_r.tbl   <= {NUM_REGS{TBL_RST}};
			st_r.ds_en <= CTRL_EN_RST;
			st_r.bresp <= RESP_OKAY;
			st_r.rresp <= RESP_OKAY;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule

/* testbench/dscp_prio_map_assertions.sv */
/*
 * Port checker for the DiffServ priority table.
 * Assumes it is bound to dscp_prio_map and sees only its top ports.
 */
`timescale 1ns/100ps
module dscp_prio_map_assertions
	import dscp_map_pkg::*;
(
	input wire logic               CLK,
	input wire logic               RST,
	input wire logic               AWVALID,
	input wire logic               AWREADY,
	input wire logic               WVALID,
	input wire logic               WREADY,
	input wire logic               BVALID,
	input wire logic [1:0]         BRESP,
	input wire logic [ADDR_W-1:0]  ARADDR,
	input wire logic               ARVALID,
	input wire logic               ARREADY,
	input wire logic               RVALID,
	input wire logic [DATA_W-1:0]  RDATA,
	input wire logic               TOS_VALID,
	input wire logic               FRAME_IS_IP,
	input wire logic [FIELD_W-1:0] ALT_PRIO,
	input wire logic               PRIO_VALID,
	input wire logic [FIELD_W-1:0] PRIO,
	input wire logic               PRIO_FROM_TABLE
);
	// ==========================================
	// Assertions, all in the switch clock domain
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	// Remembers whether the read in flight targets the table; status and hit counter use upper bits
	logic rd_tbl_r;
	always_ff @(posedge CLK) begin
		if (RST) begin
			rd_tbl_r <= 1'b0;
		end else if (ARVALID && ARREADY) begin
			rd_tbl_r <= (ARADDR[ADDR_W-1:IDX_LSB] >= IDX_TBL_FIRST) && (ARADDR[ADDR_W-1:IDX_LSB] <= IDX_TBL_LAST);
		end
	end

	a_answer_next: assert property (TOS_VALID |=> PRIO_VALID)
		else $error("frame got no answer");
	a_answer_only: assert property (!TOS_VALID |=> !PRIO_VALID)
		else $error("answer without frame");
	a_alt_path: assert property (TOS_VALID && !FRAME_IS_IP |=> PRIO == $past(ALT_PRIO) && !PRIO_FROM_TABLE)
		else $error("non-IP frame used table");
	a_prio_hold: assert property (!TOS_VALID |=> $stable(PRIO) && $stable(PRIO_FROM_TABLE))
		else $error("priority moved between frames");
	a_wr_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID)
		else $error("write answer off time");
	a_rd_answer: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	a_rd_upper: assert property (RVALID && rd_tbl_r |-> RDATA[31:8] == 24'h0)
		else $error("upper read bits set");
	a_busy_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while answering");

	// Main scenarios reached
	c_back_to_back: cover property (TOS_VALID ##1 TOS_VALID);
	c_bad_index: cover property (BVALID && BRESP == RESP_SLVERR);
	c_table_hit: cover property (PRIO_VALID && PRIO_FROM_TABLE);
endmodule

bind dscp_prio_map dscp_prio_map_assertions i_dscp_prio_map_assertions (.CLK, .RST, .AWVALID, .AWREADY,
	.WVALID, .WREADY, .BVALID, .BRESP, .ARADDR, .ARVALID, .ARREADY, .RVALID, .RDATA, .TOS_VALID, .FRAME_IS_IP,
	.ALT_PRIO, .PRIO_VALID, .PRIO, .PRIO_FROM_TABLE);

/* testbench/tb_top.sv */
/*
 * Self-checking bench for the DiffServ priority table.
 * Assumes dscp_prio_map with its checker bound; drives bus and classifier.
 */
`timescale 1ns/100ps
module tb_top
	import dscp_map_pkg::*;
;
	logic              CLK = 1'h0, RST = 1'h1;
	logic [ADDR_W-1:0] AWADDR = 10'h0, ARADDR = 10'h0;
	logic [DATA_W-1:0] WDATA = 32'h0, RDATA, rd_d;
	logic [3:0]        WSTRB = 4'h0;
	logic              AWVALID = 1'h0, WVALID = 1'h0, ARVALID = 1'h0;
	logic              BREADY = 1'h1, RREADY = 1'h1;
	logic              AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0]        BRESP, RRESP, PRIO, resp, ALT_PRIO = 2'h0;
	logic              TOS_VALID = 1'h0, FRAME_IS_IP = 1'h0, PRIO_VALID, PRIO_FROM_TABLE;
	logic [7:0]        TOS_BYTE = 8'h0;
	logic [7:0]        tbl [16];
	int                fails = 0, samples_checked = 0;

	// ==========================================
	// Clock and design
	always #50 CLK = ~CLK;

	dscp_prio_map i_dscp_prio_map (.CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
		.WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
		.RREADY, .TOS_VALID, .TOS_BYTE, .FRAME_IS_IP, .ALT_PRIO, .PRIO_VALID, .PRIO, .PRIO_FROM_TABLE);

	// ==========================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Ready sampled mid-cycle, where it is settled; release after the edge
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw, tb;
		AWADDR <= {idx, 2'h0};
		WDATA <= d;
		WSTRB <= s;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		do begin
			@(negedge CLK);
			ta = AWREADY;
			tw = WREADY;
			tb = BVALID;
			resp = BRESP;
			@(posedge CLK);
			if (ta) AWVALID <= 1'h0;
			if (tw) WVALID <= 1'h0;
		end while (!tb);
	endtask

	task automatic rd(input logic [7:0] idx);
		logic ta, tb;
		ARADDR <= {idx, 2'h0};
		ARVALID <= 1'h1;
		do begin
			@(negedge CLK);
			ta = ARREADY;
			tb = RVALID;
			rd_d = RDATA;
			resp = RRESP;
			@(posedge CLK);
			if (ta) ARVALID <= 1'h0;
		end while (!tb);
	endtask

	// One frame; called in a row it keeps TOS_VALID high at every edge
	task automatic frm(input logic [7:0] b, input logic ip, input logic [1:0] e, input logic t);
		TOS_VALID <= 1'h1;
		TOS_BYTE <= b;
		FRAME_IS_IP <= ip;
		@(posedge CLK);
		TOS_VALID <= 1'h0;
		#1;
		chk("prio", {e, t, 1'h1}, {PRIO, PRIO_FROM_TABLE, PRIO_VALID});
	endtask

	function automatic logic [1:0] pr(input logic [5:0] c);
		return tbl[c[5:2]][2*c[1:0] +: 2];
	endfunction

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================
	// Sequence
	initial begin
		for (int n = 0; n < 16; n++) tbl[n] = 8'hE4 ^ (8'(n) * 8'h1D);
		repeat (6) @(posedge CLK);
		RST <= 1'h0;
		@(posedge CLK);
		// Reset value, then write with junk in the upper bits
		for (int n = 0; n < 16; n++) begin
			rd(IDX_TBL_FIRST + 8'(n));
			chk("tbl reset", 32'h0, rd_d);
			wr(IDX_TBL_FIRST + 8'(n), {24'hA5A5A5, tbl[n]}, 4'h1);
			rd(IDX_TBL_FIRST + 8'(n));
			chk("tbl rw", {24'h0, tbl[n]}, rd_d);
		end
		// Lane zero off leaves the field alone
		wr(IDX_CODES_10_13, 32'hFF, 4'hE);
		rd(IDX_CODES_10_13);
		chk("strobe", {24'h0, tbl[4]}, rd_d);
		wr(8'h70, 32'h1, 4'hF);
		chk("wr unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
		rd(8'h70);
		chk("rd unmapped", {RESP_SLVERR, 30'h0}, {resp, rd_d[29:0]});
		// Table unused until enabled
		ALT_PRIO <= 2'h2;
		frm(8'hFC, 1'h1, 2'h2, 1'h0);
		wr(IDX_CTRL, 32'h1, 4'h1);
		for (int c = 0; c < 64; c++) frm({6'(c), 2'h3}, 1'h1, pr(6'(c)), 1'h1);
		frm(8'h40, 1'h0, 2'h2, 1'h0);
		// Status holds the last frame: prio 2, code 10, no hit, seen
		rd(IDX_STAT);
		chk("status", 32'h00000242, rd_d);
		// Every enabled IP frame of the sweep counted once
		rd(IDX_HITS);
		chk("hits", 32'h00000040, rd_d);
		wr(IDX_HITS, 32'h0, 4'h1);
		rd(IDX_HITS);
		chk("hits clear", 32'h0, rd_d);
		final_report;
	end

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#200000;
		fails++;
		final_report;
	end
endmodule
